/* verilog/nvm_ext_pkg.sv */
// constants, types and command codes of the external-programming command sequencer
// assumes a single 125 MHz clock and an apb master for the controller registers
//
// Overview of operation
// R1 - execute bit starts execute-triggered commands
// R2 - port reads start read-triggered commands
// R3 - port writes start write-triggered commands
// R4 - both locks set: only erase and crc
// R5 - chip erase clears flash, eeprom, lock bits
// R6 - eeprom keep fuse spares eeprom on erase
// R7 - port memory flag cleared during chip erase
// R8 - busy stays high until operation finishes
// R9 - generic read returns addressed byte, no busy
// R10 - dedicated read codes act like generic read
// R11 - buffer erase codes, execute bit, busy set
// R12 - buffer load writes one byte, no busy
// R13 - programmer writes low byte before high
// R14 - low byte held, high commits word
// R15 - port halted until buffer load handled
// R16 - flash page erase/write codes are write-triggered
// R17 - application page and section codes
// R18 - boot page and section codes
// R19 - user signature erase and write codes
// R20 - eeprom page codes and whole erase
// R21 - unlock needed only for self-programming
// R22 - reads blocked while controller busy
// R23 - any byte address selects whole page
// R24 - fuse and lock writes only more secure
// R25 - unknown codes do nothing
// R26 - fuse write by port, lock by execute
package nvm_ext_pkg;

	// ------------------------------------------------------------
	// widths and sizes
	// ------------------------------------------------------------
	localparam int ADDR_W     = 24;
	localparam int CMD_W      = 7;
	localparam int RESULT_W   = 24;
	localparam int FUSE_BYTES = 8;
	localparam int FBUF_AW    = 6;
	localparam int EBUF_AW    = 5;
	localparam int FBUF_WORDS = 64;
	localparam int EBUF_BYTES = 32;
	localparam logic [ADDR_W-1:0] FPAGE_MASK = 24'hFF_FF80;
	localparam logic [ADDR_W-1:0] EPAGE_MASK = 24'hFF_FFE0;

	// ------------------------------------------------------------
	// register offsets and bit positions
	// ------------------------------------------------------------
	localparam logic [11:0] REG_CMD    = 12'h000;
	localparam logic [11:0] REG_CTRL   = 12'h004;
	localparam logic [11:0] REG_STATUS = 12'h008;
	localparam logic [11:0] REG_DATA   = 12'h00C;
	localparam logic [11:0] REG_RESULT = 12'h010;
	localparam int CTRL_EXEC_BIT  = 0;
	localparam int ST_BUSY_BIT    = 0;
	localparam int ST_MEMEN_BIT   = 1;
	localparam int ST_REFUSED_BIT = 2;
	localparam int ST_HALT_BIT    = 3;
	localparam int LOCK_WRITE_BIT = 0;
	localparam int LOCK_READ_BIT  = 1;
	localparam int FUSE_KEEP_BYTE = 5;
	localparam int FUSE_KEEP_BIT  = 3;

	// ------------------------------------------------------------
	// command codes
	// ------------------------------------------------------------
	localparam logic [CMD_W-1:0] CMD_NOP = 7'h00, CMD_READ_USER = 7'h01, CMD_READ_PROD = 7'h02;
	localparam logic [CMD_W-1:0] CMD_READ_EE = 7'h06, CMD_READ_FUSE = 7'h07, CMD_WRITE_LOCK = 7'h08;
	localparam logic [CMD_W-1:0] CMD_ERASE_USER = 7'h18, CMD_WRITE_USER = 7'h1A, CMD_ERASE_APP = 7'h20;
	localparam logic [CMD_W-1:0] CMD_ERASE_APP_PG = 7'h22, CMD_LOAD_FBUF = 7'h23, CMD_WRITE_APP_PG = 7'h24;
	localparam logic [CMD_W-1:0] CMD_EW_APP_PG = 7'h25, CMD_ERASE_FBUF = 7'h26, CMD_ERASE_BOOT_PG = 7'h2A;
	localparam logic [CMD_W-1:0] CMD_ERASE_FL_PG = 7'h2B, CMD_WRITE_BOOT_PG = 7'h2C, CMD_EW_BOOT_PG = 7'h2D;
	localparam logic [CMD_W-1:0] CMD_WRITE_FL_PG = 7'h2E, CMD_EW_FL_PG = 7'h2F, CMD_ERASE_EE = 7'h30;
	localparam logic [CMD_W-1:0] CMD_ERASE_EE_PG = 7'h32, CMD_LOAD_EBUF = 7'h33, CMD_WRITE_EE_PG = 7'h34;
	localparam logic [CMD_W-1:0] CMD_EW_EE_PG = 7'h35, CMD_ERASE_EBUF = 7'h36, CMD_APP_CRC = 7'h38;
	localparam logic [CMD_W-1:0] CMD_BOOT_CRC = 7'h39, CMD_CHIP_ERASE = 7'h40, CMD_READ_NVM = 7'h43;
	localparam logic [CMD_W-1:0] CMD_WRITE_FUSE = 7'h4C, CMD_ERASE_BOOT = 7'h68, CMD_FLASH_CRC = 7'h78;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {TRIG_NONE, TRIG_EXEC, TRIG_READ, TRIG_WRITE} trig_t;
	typedef enum logic [2:0] {ST_IDLE, ST_RD_WAIT, ST_ACK, ST_BUSY, ST_BUF_CLR} state_t;

	typedef struct packed {
		trig_t trig;
		logic  prot;
		logic  busy;
		logic  fpage;
		logic  epage;
		logic  memoff;
	} cmd_info_t;

	typedef struct packed {
		logic              req;
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
	} port_req_t;

	typedef struct packed {
		logic              start;
		logic [CMD_W-1:0]  cmd;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        data;
		logic              keep_ee;
	} nvm_op_t;

endpackage

/* verilog/nvm_ext_cmd.sv */
// command decoder and sequencer of the memory controller seen from the program/debug port
// assumes an apb master, a port master holding each request until acknowledged,
// and a memory core that answers reads in the cycle of the read enable
`timescale 1ns/10ps

module nvm_ext_cmd
	import nvm_ext_pkg::*;
(
	// clock and reset
	input  wire logic                            CLK_I,
	input  wire logic                            RST_I,
	// apb register slave
	input  wire logic                            PSEL_I,
	input  wire logic                            PENABLE_I,
	input  wire logic                            PWRITE_I,
	input  wire logic [11:0]                     PADDR_I,
	input  wire logic [31:0]                     PWDATA_I,
	output logic      [31:0]                     PRDATA_O,
	output logic                                 PREADY_O,
	output logic                                 PSLVERR_O,
	input  wire logic                            SELF_PROG_I,
	input  wire logic                            UNLOCK_I,
	// program/debug port memory accesses
	input  wire port_req_t                       PORT_REQ_I,
	output logic                                 PORT_ACK_O,
	output logic      [7:0]                      PORT_RDATA_O,
	output logic                                 PORT_MEM_EN_O,
	// memory core side
	output nvm_op_t                              NVM_OP_O,
	input  wire logic                            NVM_DONE_I,
	input  wire logic [RESULT_W-1:0]             NVM_RESULT_I,
	output logic                                 NVM_RD_EN_O,
	output logic      [ADDR_W-1:0]               NVM_RD_ADDR_O,
	input  wire logic [7:0]                      NVM_RD_DATA_I,
	input  wire logic [FBUF_AW-1:0]              NVM_BUF_IDX_I,
	output logic      [15:0]                     NVM_FBUF_WORD_O,
	output logic      [7:0]                      NVM_EBUF_BYTE_O,
	output logic                                 NVM_EBUF_TAG_O,
	// nonvolatile fuse and lock values
	input  wire logic [FUSE_BYTES-1:0][7:0]      FUSE_I,
	input  wire logic [7:0]                      LOCK_I,
	output logic                                 BUSY_O
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		state_t                          st;
		logic [CMD_W-1:0]                cmd;
		logic [7:0]                      data;
		logic [RESULT_W-1:0]             result;
		logic                            busy;
		logic                            mem_off;
		logic                            refused;
		logic [7:0]                      temp_lo;
		logic [FBUF_WORDS-1:0][15:0]     fbuf;
		logic [EBUF_BYTES-1:0][7:0]      ebuf;
		logic [EBUF_BYTES-1:0]           etag;
		logic [7:0]                      rdata;
		logic                            rd_en;
		logic [ADDR_W-1:0]               rd_addr;
		nvm_op_t                         nvm;
		logic [31:0]                     prdata;
		logic [15:0]                     fbuf_rd;
		logic [7:0]                      ebuf_rd;
		logic                            etag_rd;
	} regs_t;

	regs_t s;
	regs_t next_s;

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	function automatic cmd_info_t decode_cmd(input logic [CMD_W-1:0] c);
		cmd_info_t d;
		d = '0;
		case (c)
			CMD_CHIP_ERASE: begin                                      // [R5]
				d.trig = TRIG_EXEC; d.prot = 1'b1; d.busy = 1'b1; d.memoff = 1'b1;
			end
			CMD_FLASH_CRC: begin
				d.trig = TRIG_EXEC; d.prot = 1'b1; d.busy = 1'b1; d.memoff = 1'b1;
			end
			CMD_ERASE_FBUF, CMD_ERASE_EBUF, CMD_ERASE_EE, CMD_APP_CRC, CMD_BOOT_CRC, CMD_WRITE_LOCK: begin
				d.trig = TRIG_EXEC; d.prot = 1'b1; d.busy = 1'b1;      // [R11] [R20] [R26]
			end
			CMD_READ_NVM, CMD_READ_EE, CMD_READ_FUSE, CMD_READ_USER, CMD_READ_PROD: begin
				d.trig = TRIG_READ;                                    // [R9] [R10]
			end
			CMD_LOAD_FBUF, CMD_LOAD_EBUF: begin
				d.trig = TRIG_WRITE;                                   // [R12]
			end
			CMD_ERASE_FL_PG, CMD_WRITE_FL_PG, CMD_EW_FL_PG, CMD_ERASE_APP_PG, CMD_WRITE_APP_PG,
			CMD_EW_APP_PG, CMD_ERASE_BOOT_PG, CMD_WRITE_BOOT_PG, CMD_EW_BOOT_PG: begin
				d.trig = TRIG_WRITE; d.busy = 1'b1; d.fpage = 1'b1;    // [R16] [R17] [R18] [R23]
			end
			CMD_ERASE_EE_PG, CMD_WRITE_EE_PG, CMD_EW_EE_PG: begin
				d.trig = TRIG_WRITE; d.busy = 1'b1; d.epage = 1'b1;    // [R20] [R23]
			end
			CMD_ERASE_APP, CMD_ERASE_BOOT, CMD_ERASE_USER, CMD_WRITE_USER, CMD_WRITE_FUSE: begin
				d.trig = TRIG_WRITE; d.busy = 1'b1;                    // [R17] [R18] [R19] [R26]
			end
			default: begin
				d = '0;                                                // [R25]
			end
		endcase
		return d;
	endfunction

	// ------------------------------------------------------------
	// request qualification
	// ------------------------------------------------------------
	cmd_info_t info;
	logic      apb_setup;
	logic      apb_wr;
	logic      mapped;
	logic      exec_req;
	logic      both_locked;
	logic      allowed;
	logic      unlock_ok;
	logic      take_exec;
	logic      take_port;
	logic      take_rd;
	logic      take_wr;
	logic      is_load;

	// apb decode and trigger conditions
	assign info        = decode_cmd(s.cmd);
	assign apb_setup   = PSEL_I & ~PENABLE_I;
	assign apb_wr      = PSEL_I & PENABLE_I & PWRITE_I;
	assign mapped      = (PADDR_I == REG_CMD) | (PADDR_I == REG_CTRL) | (PADDR_I == REG_STATUS) |
	                     (PADDR_I == REG_DATA) | (PADDR_I == REG_RESULT);
	assign exec_req    = apb_wr & (PADDR_I == REG_CTRL) & PWDATA_I[CTRL_EXEC_BIT];           // [R1]
	assign both_locked = ~LOCK_I[LOCK_WRITE_BIT] & ~LOCK_I[LOCK_READ_BIT];
	assign allowed     = ~both_locked | (s.cmd == CMD_CHIP_ERASE) | (s.cmd == CMD_FLASH_CRC);  // [R4]
	assign unlock_ok   = ~info.prot | ~SELF_PROG_I | UNLOCK_I;                                 // [R21]
	assign take_exec   = exec_req & (s.st == ST_IDLE) & (info.trig == TRIG_EXEC) & allowed & unlock_ok;
	assign take_port   = PORT_REQ_I.req & ~exec_req & (s.st == ST_IDLE);
	assign take_rd     = take_port & ~PORT_REQ_I.write & (info.trig == TRIG_READ) & allowed;  // [R2]
	assign take_wr     = take_port & PORT_REQ_I.write & (info.trig == TRIG_WRITE) & allowed;  // [R3]
	assign is_load     = (s.cmd == CMD_LOAD_FBUF) | (s.cmd == CMD_LOAD_EBUF);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic [31:0] rd_word;
		rd_word = '0;
		next_s = s;
		next_s.nvm.start = 1'b0;
		next_s.rd_en = 1'b0;

		// register read data is captured in the setup phase
		case (PADDR_I)
			REG_CMD:    rd_word[CMD_W-1:0] = s.cmd;
			REG_DATA:   rd_word[7:0] = s.data;
			REG_RESULT: rd_word[RESULT_W-1:0] = s.result;
			REG_STATUS: begin
				rd_word[ST_BUSY_BIT]    = s.busy;
				rd_word[ST_MEMEN_BIT]   = ~s.mem_off;
				rd_word[ST_REFUSED_BIT] = s.refused;
				rd_word[ST_HALT_BIT]    = (s.st != ST_IDLE);
			end
			default:    rd_word = '0;
		endcase
		if (apb_setup) begin
			next_s.prdata = rd_word;
		end

		// register writes; command and data are frozen while busy
		if (apb_wr & ~s.busy & (PADDR_I == REG_CMD)) begin
			next_s.cmd = PWDATA_I[CMD_W-1:0];
		end
		if (apb_wr & ~s.busy & (PADDR_I == REG_DATA)) begin
			next_s.data = PWDATA_I[7:0];
		end
		if (apb_wr & (PADDR_I == REG_STATUS) & PWDATA_I[ST_REFUSED_BIT]) begin
			next_s.refused = 1'b0;
		end

		// buffer read port toward the memory core
		next_s.fbuf_rd = s.fbuf[NVM_BUF_IDX_I];
		next_s.ebuf_rd = s.ebuf[NVM_BUF_IDX_I[EBUF_AW-1:0]];
		next_s.etag_rd = s.etag[NVM_BUF_IDX_I[EBUF_AW-1:0]];

		// execute bit: refusals set the sticky flag after any clear
		if (exec_req & (info.trig == TRIG_EXEC) & ~take_exec) begin
			next_s.refused = 1'b1;                                     // [R4] [R21]
		end

		case (s.st)
			ST_IDLE: begin
				if (take_exec) begin
					next_s.busy = 1'b1;                                // [R8]
					if ((s.cmd == CMD_ERASE_FBUF) | (s.cmd == CMD_ERASE_EBUF)) begin
						next_s.st = ST_BUF_CLR;                        // [R11]
					end else begin
						next_s.st          = ST_BUSY;
						next_s.mem_off     = info.memoff;              // [R7]
						next_s.nvm.start   = 1'b1;
						next_s.nvm.cmd     = s.cmd;
						next_s.nvm.addr    = '0;
						next_s.nvm.data    = s.data & LOCK_I;          // [R24] [R26]
						next_s.nvm.keep_ee = ~FUSE_I[FUSE_KEEP_BYTE][FUSE_KEEP_BIT]; // [R6]
					end
				end else if (take_rd) begin
					next_s.rd_en   = 1'b1;                             // [R9] [R10]
					next_s.rd_addr = PORT_REQ_I.addr;
					next_s.st      = ST_RD_WAIT;
				end else if (take_wr & is_load) begin
					next_s.st = ST_ACK;                                // [R15]
					if (s.cmd == CMD_LOAD_EBUF) begin
						next_s.ebuf[PORT_REQ_I.addr[EBUF_AW-1:0]] = PORT_REQ_I.wdata;  // [R12]
						next_s.etag[PORT_REQ_I.addr[EBUF_AW-1:0]] = 1'b1;
					end else if (~PORT_REQ_I.addr[0]) begin
						next_s.temp_lo = PORT_REQ_I.wdata;             // [R13] [R14]
					end else begin
						next_s.fbuf[PORT_REQ_I.addr[FBUF_AW:1]] = {PORT_REQ_I.wdata, s.temp_lo}; // [R14]
					end
				end else if (take_wr) begin
					next_s.st          = ST_ACK;
					next_s.busy        = 1'b1;                         // [R8]
					next_s.nvm.start   = 1'b1;                         // [R3]
					next_s.nvm.cmd     = s.cmd;
					next_s.nvm.keep_ee = 1'b0;
					if (info.fpage) begin
						next_s.nvm.addr = PORT_REQ_I.addr & FPAGE_MASK;    // [R23]
					end else if (info.epage) begin
						next_s.nvm.addr = PORT_REQ_I.addr & EPAGE_MASK;    // [R23]
					end else begin
						next_s.nvm.addr = PORT_REQ_I.addr;
					end
					if (s.cmd == CMD_WRITE_FUSE) begin
						next_s.nvm.data = PORT_REQ_I.wdata & FUSE_I[PORT_REQ_I.addr[2:0]]; // [R24] [R26]
					end else begin
						next_s.nvm.data = PORT_REQ_I.wdata;
					end
				end else if (take_port) begin
					// wrong trigger, unknown code or lock: answered, no effect
					next_s.st    = ST_ACK;                             // [R25]
					next_s.rdata = '0;
					if (~allowed) begin
						next_s.refused = 1'b1;                         // [R4]
					end
				end
			end
			ST_RD_WAIT: begin
				next_s.rdata = NVM_RD_DATA_I;
				next_s.st    = ST_ACK;
			end
			ST_ACK: begin
				next_s.st = s.busy ? ST_BUSY : ST_IDLE;
			end
			ST_BUSY: begin
				// the port stays stalled here, so no read reaches memory
				if (NVM_DONE_I) begin
					next_s.busy    = 1'b0;                             // [R8] [R22]
					next_s.mem_off = 1'b0;                             // [R7]
					next_s.st      = ST_IDLE;
					if ((s.nvm.cmd == CMD_FLASH_CRC) | (s.nvm.cmd == CMD_APP_CRC) |
					    (s.nvm.cmd == CMD_BOOT_CRC)) begin
						next_s.result = NVM_RESULT_I;
					end
				end
			end
			ST_BUF_CLR: begin
				if (s.cmd == CMD_ERASE_FBUF) begin
					next_s.fbuf = '0;                                  // [R11]
				end else begin
					next_s.ebuf = '0;
					next_s.etag = '0;
				end
				next_s.busy = 1'b0;
				next_s.st   = ST_IDLE;
			end
			default: begin
				next_s.st = ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign PREADY_O        = PSEL_I & PENABLE_I;
	assign PSLVERR_O       = PSEL_I & PENABLE_I & ~mapped;
	assign PRDATA_O        = s.prdata;
	assign PORT_ACK_O      = (s.st == ST_ACK);
	assign PORT_RDATA_O    = s.rdata;
	assign PORT_MEM_EN_O   = ~s.mem_off;
	assign NVM_OP_O        = s.nvm;
	assign NVM_RD_EN_O     = s.rd_en;
	assign NVM_RD_ADDR_O   = s.rd_addr;
	assign NVM_FBUF_WORD_O = s.fbuf_rd;
	assign NVM_EBUF_BYTE_O = s.ebuf_rd;
	assign NVM_EBUF_TAG_O  = s.etag_rd;
	assign BUSY_O          = s.busy;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	a_exec_sets_busy: assert property (take_exec |=> BUSY_O ##1  // [R1]
		(BUSY_O || $past(NVM_DONE_I) || $past(s.st) == ST_BUF_CLR))
		else $error("execute did not raise busy");
	a_read_answer: assert property (take_rd |=> NVM_RD_EN_O && !BUSY_O ##1 PORT_ACK_O &&
		PORT_RDATA_O == $past(NVM_RD_DATA_I))  // [R2]
		else $error("port read not answered with memory data");
	a_write_start: assert property (take_wr && !is_load |=> NVM_OP_O.start && BUSY_O &&
		NVM_OP_O.cmd == $past(s.cmd))  // [R3]
		else $error("port write did not start operation");
	a_lock_gate: assert property (exec_req && s.st == ST_IDLE && both_locked && info.trig == TRIG_EXEC &&  // [R4]
		s.cmd != CMD_CHIP_ERASE && s.cmd != CMD_FLASH_CRC |=> !NVM_OP_O.start && !BUSY_O && s.refused)
		else $error("locked command was accepted");
	a_keep_eeprom: assert property (take_exec && s.cmd == CMD_CHIP_ERASE |=>
		NVM_OP_O.keep_ee == !$past(FUSE_I[FUSE_KEEP_BYTE][FUSE_KEEP_BIT]))  // [R6]
		else $error("eeprom keep not passed to chip erase");
	a_port_off: assert property (take_exec && info.memoff |=> !PORT_MEM_EN_O && BUSY_O)  // [R7]
		else $error("port memory flag not cleared");
	a_busy_release: assert property (s.st == ST_BUSY && NVM_DONE_I |=> !BUSY_O && PORT_MEM_EN_O)  // [R8]
		else $error("busy not released on done");
	a_high_commit: assert property (take_wr && s.cmd == CMD_LOAD_FBUF && PORT_REQ_I.addr[0] |=>
		s.fbuf[$past(PORT_REQ_I.addr[FBUF_AW:1])] == {$past(PORT_REQ_I.wdata), $past(s.temp_lo)})  // [R14]
		else $error("flash buffer word not committed");
	a_load_halt: assert property (take_wr && is_load |=> PORT_ACK_O && !BUSY_O ##1 !PORT_ACK_O)  // [R15]
		else $error("buffer load not acknowledged once");
	a_buf_clear: assert property (take_exec && s.cmd == CMD_ERASE_EBUF |=> BUSY_O ##1 !BUSY_O && s.etag == '0)  // [R11]
		else $error("eeprom buffer not cleared");
	a_read_block: assert property (BUSY_O |-> !NVM_RD_EN_O && !PORT_ACK_O || s.st == ST_ACK)  // [R22]
		else $error("read issued while busy");
	a_page_align: assert property (take_wr && info.fpage |=> (NVM_OP_O.addr & ~FPAGE_MASK) == '0)  // [R23]
		else $error("page address not aligned");
	a_lock_secure: assert property (take_exec && s.cmd == CMD_WRITE_LOCK |=>
		(NVM_OP_O.data & ~$past(LOCK_I)) == '0)  // [R24]
		else $error("lock write made bits less secure");
	a_unknown_nop: assert property (exec_req && s.st == ST_IDLE && info.trig == TRIG_NONE |=>
		!BUSY_O && !NVM_OP_O.start)  // [R25]
		else $error("unknown code had an effect");
	a_unlock_self: assert property (exec_req && s.st == ST_IDLE && info.prot && SELF_PROG_I && !UNLOCK_I |=>
		!BUSY_O)  // [R21]
		else $error("protected command ran without unlock");

endmodule

/* dv/nvm_core_model.sv */
// memory core stand-in: ends every started operation after a set delay
// assumes the sequencer's op, read strobe and read address outputs
`timescale 1ns/10ps

module nvm_core_model
	import nvm_ext_pkg::*;
#(
	parameter int DLY = 12
) (
	// clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// sequencer side
	input  wire nvm_op_t             op_i,
	input  wire logic                rd_en_i,
	input  wire logic [ADDR_W-1:0]   rd_addr_i,
	output logic                     done_o,
	output logic      [RESULT_W-1:0] result_o,
	output logic      [7:0]          rd_data_o
);
	logic [7:0] cnt;
	logic       tgl;

	// each start restarts the countdown; done is one pulse at its end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt <= 8'h00;
			done_o <= 1'b0;
			tgl <= 1'b0;
		end else begin
			tgl <= ~tgl;
			done_o <= (cnt == 8'h01);
			if (op_i.start) begin
				cnt <= 8'(DLY);
			end else if (cnt != 8'h00) begin
				cnt <= cnt - 8'h01;
			end
		end
	end

	// read data only valid with the strobe, a changing pattern otherwise
	assign rd_data_o = rd_en_i ? (rd_addr_i[7:0] ^ 8'h5A) : {8{tgl}};
	assign result_o  = 24'h00_1234;
endmodule

/* dv/nvm_external_program_commands_tb.sv */
// self-checking bench of the command sequencer
// assumes nvm_ext_cmd and nvm_core_model
`timescale 1ns/10ps

module nvm_external_program_commands_tb;
	import nvm_ext_pkg::*;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, self_prog, unlock, ack, memen, done, rd_en, etag, busy;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [7:0] prd, rd_data, ebyte, lock, d;
	logic [23:0] rd_addr, result;
	logic [5:0] idx;
	logic [15:0] fword;
	logic [FUSE_BYTES-1:0][7:0] fuse;
	logic e, b;
	port_req_t pq;
	nvm_op_t op, o;
	int fail_count = 0;
	int checked = 0;
	logic [6:0] wcodes[17] = '{7'h2B, 7'h2E, 7'h2F, 7'h22, 7'h24, 7'h25, 7'h2A, 7'h2C, 7'h2D, 7'h18, 7'h1A,
		7'h32, 7'h34, 7'h35, 7'h20, 7'h68, 7'h4C};
	logic [6:0] xcodes[8] = '{7'h40, 7'h26, 7'h36, 7'h30, 7'h78, 7'h38, 7'h39, 7'h08};
	logic [6:0] rcodes[5] = '{7'h43, 7'h06, 7'h07, 7'h01, 7'h02};

	nvm_ext_cmd i_nvm_ext_cmd (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.SELF_PROG_I(self_prog), .UNLOCK_I(unlock), .PORT_REQ_I(pq), .PORT_ACK_O(ack), .PORT_RDATA_O(prd),
		.PORT_MEM_EN_O(memen), .NVM_OP_O(op), .NVM_DONE_I(done), .NVM_RESULT_I(result), .NVM_RD_EN_O(rd_en),
		.NVM_RD_ADDR_O(rd_addr), .NVM_RD_DATA_I(rd_data), .NVM_BUF_IDX_I(idx), .NVM_FBUF_WORD_O(fword),
		.NVM_EBUF_BYTE_O(ebyte), .NVM_EBUF_TAG_O(etag), .FUSE_I(fuse), .LOCK_I(lock), .BUSY_O(busy));
	nvm_core_model i_nvm_core_model (.clk_i(clk), .rst_i(rst), .op_i(op), .rd_en_i(rd_en), .rd_addr_i(rd_addr),
		.done_o(done), .result_o(result), .rd_data_o(rd_data));

	// ------------------------------------------------------------
	// bus tasks and compare
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		{q, e} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
	endtask
	// port request held until ack; busy and op sampled at the ack edge
	task automatic port(input logic w, input logic [23:0] a, input logic [7:0] wd);
		@(posedge clk);
		pq <= '{1'b1, w, a, wd};
		do @(posedge clk); while (ack !== 1'b1);
		{d, b, o} = {prd, busy, op};
		pq.req <= 1'b0;
	endtask
	task automatic exec(input logic [6:0] c);
		apb(1'b1, REG_CMD, {25'h0, c});
		apb(1'b1, REG_CTRL, 32'h0000_0001);
		#1;
	endtask
	task automatic idle();
		for (int i = 0; i < 100 && busy !== 1'b0; i++) @(posedge clk);
		#1;
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reads();
		apb(1'b0, 12'h014, 32'h0);
		chk(e, 1'b1);
		foreach (rcodes[i]) begin
			apb(1'b1, REG_CMD, {25'h0, rcodes[i]});
			port(1'b0, 24'h80_0010 + i, 8'h00);
			chk(d, 8'h10 + i ^ 8'h5A);
			chk(b, 1'b0);
		end
		$display("reads done");
	endtask
	task automatic t_buffers();
		apb(1'b1, REG_CMD, {25'h0, CMD_LOAD_FBUF});
		port(1'b1, 24'h80_0004, 8'h34);
		port(1'b1, 24'h80_0005, 8'h12);
		chk(b, 1'b0);
		apb(1'b1, REG_CMD, {25'h0, CMD_LOAD_EBUF});
		port(1'b1, 24'h8C_0007, 8'hA5);
		idx <= 6'd2;
		@(posedge clk);
		idx <= 6'd7;
		#1;
		chk(fword, 16'h1234);
		@(posedge clk);
		#1;
		chk({etag, ebyte}, 9'h1A5);
		$display("buffers done");
	endtask
	task automatic t_exec();
		foreach (xcodes[i]) begin
			exec(xcodes[i]);
			if (xcodes[i] == CMD_ERASE_FBUF || xcodes[i] == CMD_ERASE_EBUF) chk({busy, op.start}, 2'b10);
			else chk({busy, op.start, op.cmd}, {2'b11, xcodes[i]});
			if (xcodes[i] == CMD_CHIP_ERASE) chk({memen, op.keep_ee}, 2'b01);
			idle();
			chk({busy, memen}, 2'b01);
		end
		chk({etag, ebyte}, 9'h000);
		apb(1'b0, REG_RESULT, 32'h0);
		chk(q, 32'h0000_1234);
		$display("execute done");
	endtask
	task automatic t_writes();
		foreach (wcodes[i]) begin
			apb(1'b1, REG_CMD, {25'h0, wcodes[i]});
			port(1'b1, 24'h80_0155, 8'hFF);
			chk({b, o.start, o.cmd}, {2'b11, wcodes[i]});
			if (i < 9) chk(o.addr, 24'h80_0155 & FPAGE_MASK);
			else if (i > 10 && i < 14) chk(o.addr, 24'h80_0155 & EPAGE_MASK);
			else chk(o.addr, 24'h80_0155);
			if (wcodes[i] == CMD_WRITE_FUSE) chk(o.data, 8'hF7);
			idle();
		end
		$display("writes done");
	endtask
	task automatic t_guards();
		exec(7'h7F);
		port(1'b1, 24'h80_0155, 8'hFF);
		chk({busy, b, o.start}, 3'b000);
		lock <= 8'hFC;
		apb(1'b1, REG_CMD, {25'h0, CMD_READ_NVM});
		port(1'b0, 24'h80_0010, 8'h00);
		chk(d, 8'h00);
		exec(CMD_ERASE_EBUF);
		chk(busy, 1'b0);
		exec(CMD_CHIP_ERASE);
		chk(busy, 1'b1);
		port(1'b0, 24'h80_0010, 8'h00);
		chk(b, 1'b0);
		lock <= 8'hFF;
		apb(1'b0, REG_STATUS, 32'h0);
		chk(q, 32'h0000_0006);
		apb(1'b1, REG_STATUS, 32'h0000_0004);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(q, 32'h0000_0002);
		self_prog <= 1'b1;
		exec(CMD_ERASE_FBUF);
		chk(busy, 1'b0);
		unlock <= 1'b1;
		exec(CMD_ERASE_FBUF);
		chk(busy, 1'b1);
		idle();
		$display("guards done");
	endtask

	// ------------------------------------------------------------
	// clock, reset, sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata, self_prog, unlock, idx} = '0;
		rst = 1'b1;
		pq = '0;
		lock = 8'hFF;
		fuse = {8'hFF, 8'hFF, 8'hF7, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk({busy, memen}, 2'b01);
		t_reads();
		t_buffers();
		t_exec();
		t_writes();
		t_guards();
		final_report();
	end
	initial begin
		#200000;
		fail_count++;
		final_report();
	end
endmodule
